/* File: rtl/dfc_feature_ctrl.v */
// deserializer feature control register two and its decode
`timescale 1ns/1ps
`default_nettype none
`include "dfc_defs.vh"
// Overview of operation
// - bits 7:5 hold receive boost gain, reset 000, eight rising steps
// - bit 4 enables receive boost, reset 0
// - bits 2:0 select spread profile; 000 with low mode clear means off
// - high range codes 001-100 give 0.9/1.2/1.9/2.3 percent, divide 2168
// - high range codes 101 and 110 give 1.3 percent, divide 1300
// - low mode codes 001-101 divide 625; 001-010 1.3, others 1.8 percent
// - low mode code 110 gives 1.2, 111 gives 1.7 percent, divide 385
// - link carries 24 colour bits plus three sync bits per pixel clock
// - receiver locks to random data automatically, no training needed
// - low mode comes from bit 7 of config register zero
module dfc_feature_ctrl #(
    parameter CNT_W = 12
) (
    input wire mclk_i,
    input wire rst_i,
    input wire reg_wr_i,
    input wire [`DFC_ADDR_W-1:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    input wire link_lock_i,
    input wire [`DFC_PIX_W-1:0] link_word_i,
    output reg [23:0] pixel_colour_o,
    output reg vertical_sync_o,
    output reg horizontal_sync_o,
    output reg display_enable_o,
    output reg locked_o,
    output reg [2:0] rx_boost_gain_o,
    output reg rx_boost_enable_o,
    output reg low_freq_spread_mode_o,
    output reg spread_active_o,
    output reg [4:0] spread_deviation_o,
    output reg [CNT_W-1:0] spread_divider_o,
    output wire spread_tick_o
);
    // ==========================================================
    // registers
    reg [7:0] rx_feature_control_two;
    reg [7:0] config_one;
    reg [4:0] next_dev;
    reg [CNT_W-1:0] next_div;
    wire [2:0] spread_profile_select;
    wire low_freq;
    wire wr_feature_two;
    wire wr_config_one;

    // ==========================================================
    // decode functions
    // one address compare shared by the write and read paths
    function reg_hit;
        input [`DFC_ADDR_W-1:0] addr;
        input [`DFC_ADDR_W-1:0] ofs;
        begin
            reg_hit = (addr == ofs);
        end
    endfunction

    // unmapped addresses read zero
    function [7:0] read_mux;
        input [`DFC_ADDR_W-1:0] addr;
        input [7:0] feat;
        input [7:0] cfg;
        begin
            if (reg_hit(addr, `DFC_OFS_FEATURE_TWO))
                read_mux = feat;
            else if (reg_hit(addr, `DFC_OFS_CONFIG_ONE))
                read_mux = cfg;
            else
                read_mux = 8'h00;
        end
    endfunction

    // deviation in tenths of a percent, zero meaning off
    function [4:0] spread_dev;
        input lf;
        input [2:0] code;
        begin
            case ({lf, code})
                4'h1: spread_dev = `DFC_DEV_0P9;
                4'h2: spread_dev = `DFC_DEV_1P2;
                4'h3: spread_dev = `DFC_DEV_1P9;
                4'h4: spread_dev = `DFC_DEV_2P3;
                4'h5: spread_dev = `DFC_DEV_1P3;
                4'h6: spread_dev = `DFC_DEV_1P3;
                4'h9: spread_dev = `DFC_DEV_1P3;
                4'hA: spread_dev = `DFC_DEV_1P3;
                4'hB: spread_dev = `DFC_DEV_1P8;
                4'hC: spread_dev = `DFC_DEV_1P8;
                4'hD: spread_dev = `DFC_DEV_1P8;
                4'hE: spread_dev = `DFC_DEV_1P2;
                4'hF: spread_dev = `DFC_DEV_1P7;
                // high range 111 and low mode 000 are unlisted, so kept off
                default: spread_dev = `DFC_DEV_OFF;
            endcase
        end
    endfunction

    // off codes keep the narrow divider, matching the reset value
    function [CNT_W-1:0] spread_div;
        input lf;
        input [2:0] code;
        begin
            case ({lf, code})
                4'h5: spread_div = `DFC_DIV_HF_WIDE;
                4'h6: spread_div = `DFC_DIV_HF_WIDE;
                4'h9: spread_div = `DFC_DIV_LF_A;
                4'hA: spread_div = `DFC_DIV_LF_A;
                4'hB: spread_div = `DFC_DIV_LF_A;
                4'hC: spread_div = `DFC_DIV_LF_A;
                4'hD: spread_div = `DFC_DIV_LF_A;
                4'hE: spread_div = `DFC_DIV_LF_B;
                4'hF: spread_div = `DFC_DIV_LF_B;
                default: spread_div = `DFC_DIV_HF_NARROW;
            endcase
        end
    endfunction

    assign spread_profile_select = rx_feature_control_two[`DFC_SSC_HI:`DFC_SSC_LO];
    assign low_freq = config_one[`DFC_BIT_LOW_FREQ];
    assign wr_feature_two = reg_wr_i & reg_hit(reg_addr_i, `DFC_OFS_FEATURE_TWO);
    assign wr_config_one = reg_wr_i & reg_hit(reg_addr_i, `DFC_OFS_CONFIG_ONE);

    // ==========================================================
    // register writes
    always @(posedge mclk_i) begin
        if (rst_i) begin
            rx_feature_control_two <= `DFC_FEATURE_TWO_RST;
            config_one <= `DFC_CONFIG_ONE_RST;
        end else begin
            if (wr_feature_two)
                rx_feature_control_two <= reg_wdata_i & `DFC_FEATURE_TWO_WMASK;
            if (wr_config_one)
                config_one <= reg_wdata_i;
        end
    end

    // registered read: data follows the address one cycle late
    always @(posedge mclk_i) begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= read_mux(reg_addr_i, rx_feature_control_two, config_one);
    end

    // ==========================================================
    // spread profile decode
    always @* begin
        next_dev = spread_dev(low_freq, spread_profile_select);
        next_div = spread_div(low_freq, spread_profile_select);
    end

    // ==========================================================
    // decoded outputs
    always @(posedge mclk_i) begin
        if (rst_i) begin
            rx_boost_gain_o <= 3'h0;
            rx_boost_enable_o <= 1'b0;
            low_freq_spread_mode_o <= 1'b0;
            spread_active_o <= 1'b0;
            spread_deviation_o <= `DFC_DEV_OFF;
            spread_divider_o <= `DFC_DIV_HF_NARROW;
        end else begin
            rx_boost_gain_o <= rx_feature_control_two[`DFC_GAIN_HI:`DFC_GAIN_LO];
            rx_boost_enable_o <= rx_feature_control_two[`DFC_BIT_BOOST_EN];
            low_freq_spread_mode_o <= low_freq;
            spread_active_o <= (next_dev != `DFC_DEV_OFF);
            spread_deviation_o <= next_dev;
            spread_divider_o <= next_div;
        end
    end

    // ==========================================================
    // modulation counter
    dfc_mod_counter #(
        .CNT_W(CNT_W)
    ) u_mod (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .run_i(spread_active_o),
        .div_i(spread_divider_o),
        .tick_o(spread_tick_o),
        .count_o()
    );

    // ==========================================================
    // pixel unpack: no training, output follows lock only
    wire [5:0] colour_low;
    wire [17:0] colour_high;
    wire [2:0] sync_bits;

    assign colour_low = link_word_i[`DFC_COLOUR_LO_HI:`DFC_COLOUR_LO_LO];
    assign colour_high = link_word_i[`DFC_COLOUR_HI_HI:0];
    // display enable, vertical sync, horizontal sync, top bit first
    assign sync_bits = link_word_i[`DFC_BIT_DE:`DFC_BIT_HS];

    always @(posedge mclk_i) begin
        if (rst_i) begin
            pixel_colour_o <= 24'h000000;
            vertical_sync_o <= 1'b0;
            horizontal_sync_o <= 1'b0;
            display_enable_o <= 1'b0;
            locked_o <= 1'b0;
        end else begin
            locked_o <= link_lock_i;
            if (link_lock_i) begin
                // low six colour bits ride at the top of the word
                pixel_colour_o <= {colour_high, colour_low};
                display_enable_o <= sync_bits[2];
                vertical_sync_o <= sync_bits[1];
                horizontal_sync_o <= sync_bits[0];
            end else begin
                display_enable_o <= 1'b0;
                vertical_sync_o <= 1'b0;
                horizontal_sync_o <= 1'b0;
            end
        end
    end
endmodule // dfc_feature_ctrl
`default_nettype wire

/* File: rtl/dfc_defs.vh */
// constants for the deserializer feature control block
`ifndef DFC_DEFS_VH
`define DFC_DEFS_VH
`define DFC_ADDR_W 8
`define DFC_OFS_FEATURE_TWO 8'h03
`define DFC_OFS_CONFIG_ONE 8'h00
`define DFC_BIT_LOW_FREQ 7
`define DFC_GAIN_HI 7
`define DFC_GAIN_LO 5
`define DFC_BIT_BOOST_EN 4
`define DFC_BIT_RSVD 3
`define DFC_SSC_HI 2
`define DFC_SSC_LO 0
`define DFC_FEATURE_TWO_RST 8'h00
`define DFC_CONFIG_ONE_RST 8'h00
`define DFC_FEATURE_TWO_WMASK 8'hF7
`define DFC_DIV_HF_NARROW 12'h878
`define DFC_DIV_HF_WIDE 12'h514
`define DFC_DIV_LF_A 12'h271
`define DFC_DIV_LF_B 12'h181
`define DFC_DEV_OFF 5'h00
`define DFC_DEV_0P9 5'h09
`define DFC_DEV_1P2 5'h0C
`define DFC_DEV_1P3 5'h0D
`define DFC_DEV_1P7 5'h11
`define DFC_DEV_1P8 5'h12
`define DFC_DEV_1P9 5'h13
`define DFC_DEV_2P3 5'h17
`define DFC_PIX_W 27
`define DFC_COLOUR_LO_HI 26
`define DFC_COLOUR_LO_LO 21
`define DFC_BIT_DE 20
`define DFC_BIT_HS 18
`define DFC_COLOUR_HI_HI 17
`endif

/* File: rtl/dfc_mod_counter.v */
// modulation-rate counter: one tick every div pixel clocks
`timescale 1ns/1ps
`default_nettype none
module dfc_mod_counter #(
    parameter CNT_W = 12
) (
    input wire mclk_i,
    input wire rst_i,
    input wire run_i,
    input wire [CNT_W-1:0] div_i,
    output reg tick_o,
    output reg [CNT_W-1:0] count_o
);
    // ==========================================================
    // counter
    always @(posedge mclk_i) begin
        if (rst_i || !run_i) begin
            count_o <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (count_o >= div_i - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            // >= so a divider change mid-period cannot overrun
            count_o <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
        end else begin
            count_o <= count_o + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end
endmodule // dfc_mod_counter
`default_nettype wire

/* File: test/dfc_chk_assertions.sv */
// assertion checker for the feature control block
`timescale 1ns/1ps
`default_nettype none
module dfc_chk #(
    parameter CNT_W = 12
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [2:0] rx_boost_gain_o,
    input wire logic rx_boost_enable_o,
    input wire logic low_freq_spread_mode_o,
    input wire logic spread_active_o,
    input wire logic [4:0] spread_deviation_o,
    input wire logic [CNT_W-1:0] spread_divider_o
);
    // ====
    // checks
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence wr3; reg_wr_i && reg_addr_i == 8'h03; endsequence
    sequence wr0; reg_wr_i && reg_addr_i == 8'h00; endsequence
    wire logic lf = low_freq_spread_mode_o;
    wire logic [4:0] dv = spread_deviation_o;
    gain_follow_a: assert property (wr3 |=> ##1 rx_boost_gain_o == $past(reg_wdata_i[7:5], 2))
        else $error("gain mismatch");
    boost_follow_a: assert property (wr3 |=> ##1 rx_boost_enable_o == $past(reg_wdata_i[4], 2))
        else $error("enable mismatch");
    code_off_a: assert property (wr3 ##0 reg_wdata_i[2:0] == 3'h0 |=> ##1 !spread_active_o)
        else $error("spread not off");
    hf_narrow_a: assert property (!lf && dv inside {5'h09, 5'h0C, 5'h13, 5'h17} |-> spread_divider_o == 12'h878)
        else $error("divider not 2168");
    hf_wide_a: assert property (!lf && dv == 5'h0D |-> spread_divider_o == 12'h514)
        else $error("divider not 1300");
    lf_slow_a: assert property (lf && dv inside {5'h0D, 5'h12} |-> spread_divider_o == 12'h271)
        else $error("divider not 625");
    lf_fast_a: assert property (lf && dv inside {5'h0C, 5'h11} |-> spread_divider_o == 12'h181)
        else $error("divider not 385");
    lf_follow_a: assert property (wr0 |=> ##1 lf == $past(reg_wdata_i[7], 2))
        else $error("low mode mismatch");
    rsvd_zero_a: assert property ($past(reg_addr_i) == 8'h03 |-> !reg_rdata_o[3])
        else $error("reserved bit set");
endmodule // dfc_chk
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the feature control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ====
    // stimulus and expectations
    logic mclk_i = 0, rst_i = 1, reg_wr_i = 0, link_lock_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, d;
    logic [26:0] link_word_i = 27'h0;
    logic [31:0] seed = 32'h2129;
    wire logic [7:0] reg_rdata_o;
    wire logic [23:0] pixel_colour_o;
    wire logic vertical_sync_o, horizontal_sync_o, display_enable_o, locked_o, spread_tick_o;
    wire logic [2:0] rx_boost_gain_o;
    wire logic rx_boost_enable_o, low_freq_spread_mode_o, spread_active_o;
    wire logic [4:0] spread_deviation_o;
    wire logic [11:0] spread_divider_o;
    int fails = 0, checks_done = 0, cyc = 0, n;
    // index is {low mode, code}; unlisted codes read as off
    logic [4:0] dt [0:15] = '{5'h00, 5'h09, 5'h0C, 5'h13, 5'h17, 5'h0D, 5'h0D, 5'h00,
        5'h00, 5'h0D, 5'h0D, 5'h12, 5'h12, 5'h12, 5'h0C, 5'h11};
    logic [11:0] vt [0:15] = '{12'h878, 12'h878, 12'h878, 12'h878, 12'h878, 12'h514, 12'h514,
        12'h878, 12'h878, 12'h271, 12'h271, 12'h271, 12'h271, 12'h271, 12'h181, 12'h181};
    dfc_feature_ctrl uut (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .link_lock_i(link_lock_i),
        .link_word_i(link_word_i),
        .pixel_colour_o(pixel_colour_o),
        .vertical_sync_o(vertical_sync_o),
        .horizontal_sync_o(horizontal_sync_o),
        .display_enable_o(display_enable_o),
        .locked_o(locked_o),
        .rx_boost_gain_o(rx_boost_gain_o),
        .rx_boost_enable_o(rx_boost_enable_o),
        .low_freq_spread_mode_o(low_freq_spread_mode_o),
        .spread_active_o(spread_active_o),
        .spread_deviation_o(spread_deviation_o),
        .spread_divider_o(spread_divider_o),
        .spread_tick_o(spread_tick_o)
    );
    always #2 mclk_i = ~mclk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobe dropped for a full cycle, so no double assignment at one step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr_i = a;
        reg_wdata_i = v;
        reg_wr_i = 1;
        @(negedge mclk_i);
        reg_wr_i = 0;
        @(negedge mclk_i);
    endtask
    task automatic end_of_test;
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(negedge mclk_i);
        rst_i = 0;
        @(negedge mclk_i);
        cmp(spread_divider_o, 12'h878);
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            wr(8'h00, {i[3], seed[6:0]});
            d = {seed[15:12], 1'b1, i[2:0]};
            wr(8'h03, d);
            cmp(reg_rdata_o, d & 8'hF7);
            cmp({rx_boost_gain_o, rx_boost_enable_o}, d[7:4]);
            cmp(low_freq_spread_mode_o, i[3]);
            cmp({spread_active_o, spread_deviation_o}, {dt[i] != 0, dt[i]});
            cmp(spread_divider_o, vt[i]);
        end
        wr(8'h55, 8'hFF);
        cmp({reg_rdata_o, rx_boost_gain_o}, {8'h00, d[7:5]});
        n = 0;
        while (spread_tick_o !== 1'b1) @(negedge mclk_i);
        @(negedge mclk_i);
        while (spread_tick_o !== 1'b1) begin
            n++;
            @(negedge mclk_i);
        end
        cmp(n + 1, 12'h181);
        link_lock_i = 1;
        repeat (8) begin
            seed = lfsr(seed);
            link_word_i = seed[26:0];
            @(negedge mclk_i);
            cmp(pixel_colour_o, {seed[17:0], seed[26:21]});
            cmp({locked_o, vertical_sync_o, horizontal_sync_o, display_enable_o},
                {1'b1, seed[19], seed[18], seed[20]});
        end
        link_lock_i = 0;
        @(negedge mclk_i);
        cmp({locked_o, vertical_sync_o, horizontal_sync_o, display_enable_o}, 4'h0);
        // mid-run reset must clear the registers, not only the output flops
        wr(8'h03, 8'hF5);
        cmp(rx_boost_gain_o, 3'h7);
        rst_i = 1;
        repeat (2) @(negedge mclk_i);
        rst_i = 0;
        @(negedge mclk_i);
        cmp({reg_rdata_o, rx_boost_gain_o, rx_boost_enable_o, low_freq_spread_mode_o}, 24'h0);
        cmp({spread_active_o, spread_deviation_o, spread_divider_o}, {6'h00, 12'h878});
        end_of_test();
    end
endmodule // tb_top
bind dfc_feature_ctrl dfc_chk #(.CNT_W(CNT_W)) chk (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .rx_boost_gain_o(rx_boost_gain_o),
    .rx_boost_enable_o(rx_boost_enable_o),
    .low_freq_spread_mode_o(low_freq_spread_mode_o),
    .spread_active_o(spread_active_o),
    .spread_deviation_o(spread_deviation_o),
    .spread_divider_o(spread_divider_o)
);
`default_nettype wire
